//--- logic/lcdc_top.sv
/*
  Segment LCD driver control: display mode and inversion, contrast code,
  regulator options, lcd clock selection and prescale, frame generation,
  frame pin and frame interrupt, behind an AXI4-Lite slave.
  Assumes the oscillator inputs arrive as one-cycle tick enables synchronous
  to aclk, and that sleep_active is a synchronous level from the processor.
*/
// Design decision made here: the AXI4-Lite register port.
// Operation
// - display_invert 0 shows inverted image, 1 normal; memory untouched
// - display_mode_sel: 0 off, 1 normal, 2 all on dynamic, 3 all off static
// - display off stops regulator drive, all three voltages held at ground
// - all-on/all-off act on waveform only; commons dynamic or static
// - display_mode_sel resets to display off
// - sleep forces display off; prior mode returns after sleep
// - four-bit contrast_level sets regulator voltage, 0xF dark, resets 0x7
// - frame_divider_sel divides lcd clock by 256, 512, 680, 1024; reset 1
// - in one-third duty divisors become 252, 504, 681, 1008
// - high-speed source prescaled 1/32 to 1/512 before frame divider
// - frame_pin_output_en 1 drives frame on pin; 0 holds pin low
// - drive_duty_sel 4 eighth, 3 quarter, 2 third, 1 half, 0 static
// - eighth duty limits segments to 52 or 36, else 56 or 40
// - regulator register: heavy_load_protect at D4, vref_select at D0
// - frame_irq_enable gates frame requests to irq controller
// - frame_irq_flag set on every frame signal rising edge
// - writing 1 clears frame_irq_flag, 0 ignored, read shows flag
// - interrupt line high while flag and enable both set
// - lcd clock from low-speed osc or prescaled high-speed, gated by enable
`timescale 1ns/1ps
module lcdc_top
  import lcdc_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_speed_osc_tick,
  input wire logic high_speed_clock_tick,
  input wire logic sleep_active,
  output lcdc_drive_t drive_state,
  output logic regulator_on,
  output logic vc_hold_ground,
  output logic com_static_drive,
  output logic image_inverted,
  output logic [3:0] contrast_level,
  output logic heavy_load_protect,
  output logic vref_select,
  output logic [2:0] drive_duty_sel,
  output logic [5:0] segments_used,
  output logic frame_signal,
  output logic frame_signal_pin,
  output logic frame_irq
);

  // ==========================================================================
  // software registers
  lcdc_display_t display_r;
  lcdc_frame_duty_t frame_duty_r;
  lcdc_clock_sel_t clock_sel_r;
  logic [3:0] contrast_r;
  logic heavy_load_r;
  logic vref_r;
  logic irq_enable_r;
  logic irq_flag_r;

  // ==========================================================================
  // AXI4-Lite write path: address and data may arrive in either order
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-3:0] waddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
  // readies are registered: they drop at the edge of a handshake, never later
  wire aw_held_nxt = !wr_fire && (aw_held_r || aw_take);
  wire w_held_nxt = !wr_fire && (w_held_r || w_take);
  wire bvalid_nxt = wr_fire || (bvalid_r && !s_axi_bready);

  wire hit_w_clk = waddr_r == (ADDR_W-2)'(IDX_CLOCK_SELECT);
  wire hit_w_dsp = waddr_r == (ADDR_W-2)'(IDX_DISPLAY_CTRL);
  wire hit_w_con = waddr_r == (ADDR_W-2)'(IDX_CONTRAST);
  wire hit_w_frm = waddr_r == (ADDR_W-2)'(IDX_FRAME_DUTY);
  wire hit_w_reg = waddr_r == (ADDR_W-2)'(IDX_REGULATOR);
  wire hit_w_msk = waddr_r == (ADDR_W-2)'(IDX_IRQ_MASK);
  wire hit_w_flg = waddr_r == (ADDR_W-2)'(IDX_IRQ_FLAG);
  wire w_mapped = hit_w_clk || hit_w_dsp || hit_w_con || hit_w_frm || hit_w_reg
                  || hit_w_msk || hit_w_flg;
  // only byte lane 0 carries register bits; other lanes are read-as-zero
  wire wr_en = wr_fire && wlane_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        waddr_r <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
      s_axi_wready <= !w_held_nxt && !bvalid_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ==========================================================================
  // sleep masks the mode without losing the stored value
  // a write during sleep still lands in the stored mode
  wire [1:0] mode_eff = sleep_active ? MODE_OFF : display_r.mode;

  // ==========================================================================
  // AXI4-Lite read path
  logic rvalid_r;
  logic [7:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);
  wire [ADDR_W-3:0] raddr = s_axi_araddr[ADDR_W-1:2];

  wire hit_r_clk = raddr == (ADDR_W-2)'(IDX_CLOCK_SELECT);
  wire hit_r_dsp = raddr == (ADDR_W-2)'(IDX_DISPLAY_CTRL);
  wire hit_r_con = raddr == (ADDR_W-2)'(IDX_CONTRAST);
  wire hit_r_frm = raddr == (ADDR_W-2)'(IDX_FRAME_DUTY);
  wire hit_r_reg = raddr == (ADDR_W-2)'(IDX_REGULATOR);
  wire hit_r_msk = raddr == (ADDR_W-2)'(IDX_IRQ_MASK);
  wire hit_r_flg = raddr == (ADDR_W-2)'(IDX_IRQ_FLAG);
  wire r_mapped = hit_r_clk || hit_r_dsp || hit_r_con || hit_r_frm || hit_r_reg
                  || hit_r_msk || hit_r_flg;

  wire [7:0] rd_clk = {3'h0, clock_sel_r};
  wire [7:0] rd_dsp = {3'h0, display_r.invert, 2'h0, mode_eff};
  wire [7:0] rd_con = {4'h0, contrast_r};
  wire [7:0] rd_frm = {frame_duty_r.frame_div, frame_duty_r.frame_pin_en, 2'h0,
                       frame_duty_r.duty};
  wire [7:0] rd_reg = {3'h0, heavy_load_r, 3'h0, vref_r};
  wire [7:0] rd_msk = {7'h00, irq_enable_r};
  wire [7:0] rd_flg = {7'h00, irq_flag_r};
  wire [7:0] rd_mux = ({8{hit_r_clk}} & rd_clk) | ({8{hit_r_dsp}} & rd_dsp)
                    | ({8{hit_r_con}} & rd_con) | ({8{hit_r_frm}} & rd_frm)
                    | ({8{hit_r_reg}} & rd_reg) | ({8{hit_r_msk}} & rd_msk)
                    | ({8{hit_r_flg}} & rd_flg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      s_axi_arready <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_r <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = {24'h000000, rdata_r};
  assign s_axi_rresp = rresp_r;

  // ==========================================================================
  // register writes; reserved bits are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_r <= '{invert: RST_INVERT, mode: RST_MODE};
      contrast_r <= RST_CONTRAST;
      frame_duty_r <= '{frame_div: RST_FRAME_DIV, frame_pin_en: 1'b0,
                        duty: RST_DUTY};
      clock_sel_r <= '{prescale: RST_PRESCALE, src_low_speed: RST_CLK_SRC,
                       gate: 1'b0};
      heavy_load_r <= 1'b0;
      vref_r <= 1'b0;
      irq_enable_r <= 1'b0;
    end else if (wr_en) begin
      if (hit_w_dsp) begin
        display_r.invert <= wdata_r[POS_DISPLAY_INVERT];
        display_r.mode <= wdata_r[1:0];
      end
      if (hit_w_con) begin
        contrast_r <= wdata_r[3:0];
      end
      if (hit_w_frm) begin
        frame_duty_r.frame_div <= wdata_r[POS_FRAME_DIV +: 2];
        frame_duty_r.frame_pin_en <= wdata_r[POS_FRAME_PIN_EN];
        frame_duty_r.duty <= wdata_r[2:0];
      end
      if (hit_w_reg) begin
        heavy_load_r <= wdata_r[POS_HEAVY_LOAD];
        vref_r <= wdata_r[POS_VREF_SEL];
      end
      if (hit_w_clk) begin
        clock_sel_r.prescale <= wdata_r[POS_PRESCALE +: 3];
        clock_sel_r.src_low_speed <= wdata_r[POS_CLK_SRC];
        clock_sel_r.gate <= wdata_r[POS_CLK_GATE];
      end
      if (hit_w_msk) begin
        irq_enable_r <= wdata_r[0];
      end
    end
  end

  // ==========================================================================
  // lcd clock: low-speed tick, or high-speed tick prescaled 1/32..1/512
  logic [9:0] pre_cnt_r;
  // reserved prescale codes clamp to the slowest ratio
  wire [2:0] pre_code = (clock_sel_r.prescale > PRESCALE_MAX) ? PRESCALE_MAX
                        : clock_sel_r.prescale;
  wire [9:0] pre_last = (PRESCALE_BASE << pre_code) - 10'd1;
  wire pre_wrap = high_speed_clock_tick && (pre_cnt_r >= pre_last);
  wire hs_lcd_tick = pre_wrap;
  wire lcd_clock_tick = clock_sel_r.gate && (clock_sel_r.src_low_speed ?
                        low_speed_osc_tick : hs_lcd_tick);

  always_ff @(posedge aclk) begin
    if (!aresetn || clock_sel_r.src_low_speed) begin
      pre_cnt_r <= 10'd0;
    end else if (high_speed_clock_tick) begin
      pre_cnt_r <= pre_wrap ? 10'd0 : pre_cnt_r + 10'd1;
    end
  end

  // ==========================================================================
  // frame generator: count lcd clock ticks over the selected divider
  wire third_duty = frame_duty_r.duty == DUTY_THIRD;
  logic [10:0] fdiv;
  always_comb begin
    case (frame_duty_r.frame_div)
      2'h0: fdiv = third_duty ? FDIV3_0 : FDIV_0;
      2'h1: fdiv = third_duty ? FDIV3_1 : FDIV_1;
      2'h2: fdiv = third_duty ? FDIV3_2 : FDIV_2;
      default: fdiv = third_duty ? FDIV3_3 : FDIV_3;
    endcase
  end

  logic [10:0] frame_cnt_r;
  logic frame_r;
  // a divider change below the current count ends the frame at once, no long gap
  wire frame_wrap = frame_cnt_r >= fdiv - 11'd1;
  wire [10:0] frame_cnt_nxt = frame_wrap ? 11'd0 : frame_cnt_r + 11'd1;
  // high from mid-count to wrap, low after; one rising edge per frame
  wire frame_nxt = frame_cnt_nxt >= {1'b0, fdiv[10:1]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt_r <= 11'd0;
      frame_r <= 1'b0;
    end else if (lcd_clock_tick) begin
      frame_cnt_r <= frame_cnt_nxt;
      frame_r <= frame_nxt;
    end
  end

  logic frame_d_r;
  wire frame_rise = frame_r && !frame_d_r;

  // ==========================================================================
  // frame interrupt: a rising edge wins over a same-cycle clear
  wire flag_clear = wr_en && hit_w_flg && wdata_r[0];
  wire irq_flag_nxt = frame_rise ? 1'b1 : (flag_clear ? 1'b0 : irq_flag_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_d_r <= 1'b0;
      irq_flag_r <= 1'b0;
      frame_irq <= 1'b0;
    end else begin
      frame_d_r <= frame_r;
      irq_flag_r <= irq_flag_nxt;
      frame_irq <= irq_flag_nxt && irq_enable_r;
    end
  end

  // ==========================================================================
  // drive state and panel-side outputs
  lcdc_drive_t drive_nxt;
  always_comb begin
    case (mode_eff)
      MODE_OFF: drive_nxt = DRV_OFF;
      MODE_NORMAL: drive_nxt = DRV_NORMAL;
      MODE_ALL_ON: drive_nxt = DRV_ALL_ON;
      MODE_ALL_OFF: drive_nxt = DRV_ALL_OFF;
      default: drive_nxt = DRV_OFF;
    endcase
  end

  wire [5:0] segs_nxt = (frame_duty_r.duty == DUTY_EIGHTH)
                        ? (LARGE_VARIANT ? SEGS_LARGE_EIGHTH : SEGS_SMALL_EIGHTH)
                        : (LARGE_VARIANT ? SEGS_LARGE : SEGS_SMALL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_state <= DRV_OFF;
      regulator_on <= 1'b0;
      vc_hold_ground <= 1'b1;
      com_static_drive <= 1'b0;
      image_inverted <= 1'b0;
      contrast_level <= RST_CONTRAST;
      heavy_load_protect <= 1'b0;
      vref_select <= 1'b0;
      drive_duty_sel <= RST_DUTY;
      segments_used <= LARGE_VARIANT ? SEGS_LARGE_EIGHTH : SEGS_SMALL_EIGHTH;
      frame_signal <= 1'b0;
      frame_signal_pin <= 1'b0;
    end else begin
      drive_state <= drive_nxt;
      regulator_on <= drive_nxt != DRV_OFF;
      vc_hold_ground <= drive_nxt == DRV_OFF;
      // waveform-level override; display memory is never touched here
      com_static_drive <= (drive_nxt == DRV_ALL_OFF)
                          || (frame_duty_r.duty == DUTY_STATIC);
      // all-off image cannot be inverted, all-on can
      image_inverted <= !display_r.invert && (drive_nxt != DRV_ALL_OFF);
      contrast_level <= contrast_r;
      heavy_load_protect <= heavy_load_r;
      vref_select <= vref_r;
      drive_duty_sel <= frame_duty_r.duty;
      segments_used <= segs_nxt;
      frame_signal <= frame_r;
      frame_signal_pin <= frame_duty_r.frame_pin_en && frame_r;
    end
  end

endmodule

//--- shared/lcdc_pkg.sv
/*
  Package for the segment LCD driver control block: register indices, field
  layouts, reset values, divider tables and the drive-state encoding.
  Assumes a 32-bit AXI4-Lite register bus where byte address = 4 * index.
*/
package lcdc_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_CLOCK_SELECT = 16'h5063;
  localparam logic [15:0] IDX_DISPLAY_CTRL = 16'h50A0;
  localparam logic [15:0] IDX_CONTRAST = 16'h50A1;
  localparam logic [15:0] IDX_FRAME_DUTY = 16'h50A2;
  localparam logic [15:0] IDX_REGULATOR = 16'h50A3;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h50A5;
  localparam logic [15:0] IDX_IRQ_FLAG = 16'h50A6;

  // ==========================================================================
  // field positions inside the 8-bit registers
  localparam int POS_DISPLAY_INVERT = 4;
  localparam int POS_FRAME_DIV = 6;
  localparam int POS_FRAME_PIN_EN = 5;
  localparam int POS_HEAVY_LOAD = 4;
  localparam int POS_VREF_SEL = 0;
  localparam int POS_PRESCALE = 2;
  localparam int POS_CLK_SRC = 1;
  localparam int POS_CLK_GATE = 0;

  // ==========================================================================
  // mode and duty codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_ALL_ON = 2'h2;
  localparam logic [1:0] MODE_ALL_OFF = 2'h3;
  localparam logic [2:0] DUTY_STATIC = 3'h0;
  localparam logic [2:0] DUTY_THIRD = 3'h2;
  localparam logic [2:0] DUTY_EIGHTH = 3'h4;
  localparam logic [2:0] PRESCALE_MAX = 3'h4;

  // ==========================================================================
  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic RST_INVERT = 1'b1;
  localparam logic [3:0] RST_CONTRAST = 4'h7;
  localparam logic [1:0] RST_FRAME_DIV = 2'h1;
  localparam logic [2:0] RST_DUTY = 3'h4;
  localparam logic [2:0] RST_PRESCALE = 3'h0;
  localparam logic RST_CLK_SRC = 1'b1;

  // ==========================================================================
  // frame dividers in lcd clock cycles, normal duties and one-third duty
  localparam logic [10:0] FDIV_0 = 11'd256;
  localparam logic [10:0] FDIV_1 = 11'd512;
  localparam logic [10:0] FDIV_2 = 11'd680;
  localparam logic [10:0] FDIV_3 = 11'd1024;
  localparam logic [10:0] FDIV3_0 = 11'd252;
  localparam logic [10:0] FDIV3_1 = 11'd504;
  localparam logic [10:0] FDIV3_2 = 11'd681;
  localparam logic [10:0] FDIV3_3 = 11'd1008;
  // high-speed prescale base ratio 1/32, doubled per code step
  localparam logic [9:0] PRESCALE_BASE = 10'd32;

  // segment limits per variant
  localparam logic [5:0] SEGS_LARGE_EIGHTH = 6'd52;
  localparam logic [5:0] SEGS_LARGE = 6'd56;
  localparam logic [5:0] SEGS_SMALL_EIGHTH = 6'd36;
  localparam logic [5:0] SEGS_SMALL = 6'd40;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic invert;
    logic [1:0] mode;
  } lcdc_display_t;

  typedef struct packed {
    logic [1:0] frame_div;
    logic frame_pin_en;
    logic [2:0] duty;
  } lcdc_frame_duty_t;

  typedef struct packed {
    logic [2:0] prescale;
    logic src_low_speed;
    logic gate;
  } lcdc_clock_sel_t;

  typedef enum logic [3:0] {
    DRV_OFF = 4'b0001,
    DRV_NORMAL = 4'b0010,
    DRV_ALL_ON = 4'b0100,
    DRV_ALL_OFF = 4'b1000
  } lcdc_drive_t;

endpackage

//--- tb/lcdc_assertions.sv
/*
  Port-level properties of the lcd driver control block.
  Assumes binding onto lcdc_top, with the variant parameter handed on.
*/
`timescale 1ns/1ps
module lcdc_assertions
  import lcdc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_active,
  input wire lcdc_drive_t drive_state,
  input wire logic regulator_on,
  input wire logic vc_hold_ground,
  input wire logic com_static_drive,
  input wire logic image_inverted,
  input wire logic [3:0] contrast_level,
  input wire logic [2:0] drive_duty_sel,
  input wire logic [5:0] segments_used,
  input wire logic frame_signal,
  input wire logic frame_signal_pin
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam logic [5:0] SEG8 = LARGE_VARIANT ? SEGS_LARGE_EIGHTH : SEGS_SMALL_EIGHTH;
  localparam logic [5:0] SEGN = LARGE_VARIANT ? SEGS_LARGE : SEGS_SMALL;

  property p_onehot;
    $onehot(drive_state);
  endproperty
  property p_off;
    drive_state == DRV_OFF |-> vc_hold_ground && !regulator_on;
  endproperty
  property p_on;
    drive_state != DRV_OFF |-> regulator_on && !vc_hold_ground;
  endproperty
  property p_all_on;
    drive_state == DRV_ALL_ON && drive_duty_sel != DUTY_STATIC |-> !com_static_drive;
  endproperty
  property p_all_off;
    drive_state == DRV_ALL_OFF |-> com_static_drive && !image_inverted;
  endproperty
  // mode forcing takes one register stage behind the sleep level; the check allows two
  property p_sleep;
    sleep_active [*3] |-> drive_state == DRV_OFF;
  endproperty
  property p_reset;
    $rose(aresetn) |-> drive_state == DRV_OFF && contrast_level == 4'h7;
  endproperty
  property p_segs;
    drive_duty_sel == DUTY_EIGHTH |-> segments_used == SEG8;
  endproperty
  property p_segs_n;
    drive_duty_sel < DUTY_EIGHTH |-> segments_used == SEGN;
  endproperty
  property p_pin;
    frame_signal_pin |-> frame_signal;
  endproperty

  a_onehot: assert property (p_onehot) else $error("drive state not one-hot");
  a_off: assert property (p_off) else $error("off mode drives regulator");
  a_on: assert property (p_on) else $error("regulator idle while on");
  a_all_on: assert property (p_all_on) else $error("all-on commons static");
  a_all_off: assert property (p_all_off) else $error("all-off drive wrong");
  a_sleep: assert property (p_sleep) else $error("sleep did not force off");
  a_reset: assert property (p_reset) else $error("reset values wrong");
  a_segs: assert property (p_segs) else $error("eighth duty segment limit");
  a_segs_n: assert property (p_segs_n) else $error("segment limit wrong");
  a_pin: assert property (p_pin) else $error("frame pin without frame");

  c_pin: cover property ($rose(frame_signal_pin));
  c_all_on: cover property (drive_state == DRV_ALL_ON);
  c_sleep: cover property (sleep_active [*3]);
endmodule

bind lcdc_top lcdc_assertions #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .sleep_active(sleep_active),
  .drive_state(drive_state), .regulator_on(regulator_on),
  .vc_hold_ground(vc_hold_ground), .com_static_drive(com_static_drive),
  .image_inverted(image_inverted), .contrast_level(contrast_level),
  .drive_duty_sel(drive_duty_sel), .segments_used(segments_used),
  .frame_signal(frame_signal), .frame_signal_pin(frame_signal_pin));

//--- tb/lcdc_panel_model.sv
/*
  Far-side model: oscillator ticks into the block and a panel counting
  frame pin rising edges. Assumes one aclk domain.
*/
`timescale 1ns/1ps
module lcdc_panel_model (
  input wire logic aclk,
  input wire logic run,
  input wire logic frame_signal_pin,
  output logic low_speed_osc_tick,
  output logic high_speed_clock_tick,
  output int pin_rises
);
  // ==========================================================================
  // ticks every cycle keep frames short; both sources run together
  logic pin_q = 1'b0;
  initial begin
    low_speed_osc_tick = 1'b0;
    high_speed_clock_tick = 1'b0;
    pin_rises = 0;
  end
  always @(posedge aclk) begin
    low_speed_osc_tick <= run;
    high_speed_clock_tick <= run;
    pin_q <= frame_signal_pin;
    if (frame_signal_pin && !pin_q) begin
      pin_rises <= pin_rises + 1;
    end
  end
endmodule

//--- tb/tb_top.sv
/*
  Bench for lcdc_top: AXI4-Lite register tasks and sequences for modes,
  duty, frame timing, frame pin, sleep and the frame interrupt.
  Assumes the panel model supplies the oscillator ticks.
*/
`timescale 1ns/1ps
module tb_top;
  import lcdc_pkg::*;
  // ==========================================================================
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic sleep_active = 1'b0, run = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata;
  logic low_speed_osc_tick, high_speed_clock_tick, regulator_on, vc_hold_ground;
  logic com_static_drive, image_inverted, heavy_load_protect, vref_select;
  logic frame_signal, frame_signal_pin, frame_irq;
  lcdc_drive_t drive_state;
  logic [3:0] contrast_level;
  logic [2:0] drive_duty_sel;
  logic [5:0] segments_used;
  logic [7:0] rdv;
  int pin_rises, per_n, n0;
  int n_errors = 0, checks_done = 0;
  logic [15:0] ridx [7] = '{IDX_DISPLAY_CTRL, IDX_CONTRAST, IDX_FRAME_DUTY,
    IDX_REGULATOR, IDX_IRQ_MASK, IDX_IRQ_FLAG, IDX_CLOCK_SELECT};
  logic [7:0] rval [7] = '{8'h10, 8'h07, 8'h44, 8'h00, 8'h00, 8'h00, 8'h02};
  int fd [8] = '{256, 512, 680, 1024, 252, 504, 681, 1008};

  always #20 aclk = ~aclk;

  lcdc_top #(.ADDR_W(32), .LARGE_VARIANT(1'b1)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_speed_osc_tick,
    .high_speed_clock_tick, .sleep_active, .drive_state, .regulator_on,
    .vc_hold_ground, .com_static_drive, .image_inverted, .contrast_level,
    .heavy_load_protect, .vref_select, .drive_duty_sel, .segments_used,
    .frame_signal, .frame_signal_pin, .frame_irq);

  lcdc_panel_model u_panel (.aclk, .run, .frame_signal_pin, .low_speed_osc_tick,
    .high_speed_clock_tick, .pin_rises);

  // ==========================================================================
  // tasks
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tmo;
    n_errors++;
    $display("[FAIL] %0t wait limit reached", $time);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // handshakes are judged at the negedge: the readies only move after posedges
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic a, w, b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {14'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 100 && !b; n++) begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    if (!b) tmo();
  endtask

  task automatic rd(input logic [15:0] idx);
    logic a, r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {14'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 100 && !r; n++) begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rdv = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    if (!r) tmo();
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(rdv, exp);
    chk(rsp, RESP_OKAY);
  endtask

  task automatic settle;
    @(posedge aclk);
    @(negedge aclk);
  endtask

  // cycles between the second and third frame rise; the first may be cut short
  task automatic per;
    int k = 0;
    logic q = 1'b1;
    per_n = 0;
    for (int n = 0; n < 40000 && k < 3; n++) begin
      @(negedge aclk);
      per_n++;
      if (frame_signal && !q) begin
        k++;
        if (k == 2) per_n = 0;
      end
      q = frame_signal;
    end
    if (k < 3) tmo();
  endtask

  // ==========================================================================
  // sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(ridx[i], rval[i]);
    rd(16'h50A4);
    chk(rsp, RESP_SLVERR);
    chk(rdv, 8'h00);
    wr(16'h50A4, 8'hFF);
    chk(rsp, RESP_SLVERR);
    wr(IDX_CONTRAST, 8'h0F);
    settle();
    chk(contrast_level, 4'hF);
    wr(IDX_REGULATOR, 8'h11);
    settle();
    chk({heavy_load_protect, vref_select}, 2'h3);
    rdc(IDX_REGULATOR, 8'h11);
    wr(IDX_CLOCK_SELECT, 8'h03);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_DISPLAY_CTRL, {3'h0, i[2], 2'h0, i[1:0]});
      settle();
      chk(drive_state, 32'h1 << i[1:0]);
      chk(regulator_on, i[1:0] != 2'h0);
      chk(vc_hold_ground, i[1:0] == 2'h0);
      chk(com_static_drive, i[1:0] == 2'h3);
      chk(image_inverted, !i[2] && i[1:0] != 2'h3);
    end
    wr(IDX_DISPLAY_CTRL, 8'h11);
    sleep_active <= 1'b1;
    repeat (3) @(posedge aclk);
    rdc(IDX_DISPLAY_CTRL, 8'h10);
    settle();
    chk(drive_state, DRV_OFF);
    @(posedge aclk);
    sleep_active <= 1'b0;
    settle();
    settle();
    chk(drive_state, DRV_NORMAL);
    for (int d = 0; d < 5; d++) begin
      wr(IDX_FRAME_DUTY, 8'h40 | d[7:0]);
      settle();
      chk(drive_duty_sel, d);
      chk(segments_used, (d == 4) ? 52 : 56);
      chk(com_static_drive, d == 0);
    end
    for (int k = 0; k < 8; k++) begin
      wr(IDX_FRAME_DUTY, {k[1:0], 3'h4, k[2] ? DUTY_THIRD : DUTY_EIGHTH});
      per();
      chk(per_n, fd[k]);
    end
    chk(pin_rises > 0, 1'b1);
    wr(IDX_FRAME_DUTY, 8'h04);
    settle();
    n0 = pin_rises;
    repeat (1100) @(posedge aclk);
    chk(pin_rises, n0);
    chk(frame_signal_pin, 1'b0);
    wr(IDX_CLOCK_SELECT, 8'h01);
    per();
    chk(per_n, 32 * 256);
    wr(IDX_CLOCK_SELECT, 8'h03);
    wr(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    n0 = 0;
    do begin
      @(negedge aclk);
      n0++;
    end while (frame_irq !== 1'b1 && n0 < 2000);
    if (n0 >= 2000) tmo();
    chk(frame_irq, 1'b1);
    rdc(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_FLAG, 8'h00);
    rdc(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_FLAG, 8'h01);
    rdc(IDX_IRQ_FLAG, 8'h00);
    settle();
    chk(frame_irq, 1'b0);
    wr(IDX_IRQ_MASK, 8'h00);
    per();
    settle();
    settle();
    chk(frame_irq, 1'b0);
    rdc(IDX_IRQ_FLAG, 8'h01);
    report_and_stop();
  end
endmodule
